// *** verilog/predriver_params.svh ***
// offsets, field positions and reset values of the threshold, slew and bias registers
`ifndef PREDRIVER_PARAMS_SVH
`define PREDRIVER_PARAMS_SVH
`define ADDR_HS_DRAIN 9'h18a
`define ADDR_HS_SOURCE 9'h18b
`define ADDR_LS_DRAIN_LO 9'h18c
`define ADDR_LS_DRAIN_HI 9'h18d
`define ADDR_HS_SPEED 9'h18e
`define ADDR_LS_SPEED 9'h18f
`define ADDR_BIAS 9'h1a4
`define RST_REG 16'h0000
`define MASK_THR5 16'h7fff
`define MASK_THR1 16'h0007
`define MASK_HS_SPEED 16'h03ff
`define MASK_LS_SPEED 16'hffff
`define MASK_BIAS 16'h1fff
`define HS_SRC_HALF_VOLT 3'h1
`define HS_SRC_ONE_VOLT 3'h2
`define BIAS_HS_PU_LSB 0
`define BIAS_LS_PD_LSB 5
`define BIAS_HS2_STRONG 11
`define BIAS_HS4_STRONG 12
`define NUM_CORES 4
`endif

// *** verilog/predriver_pkg.sv ***
// types shared by the threshold, slew and bias register bank
package predriver_pkg;
   // one register access from a host or a microcore
   typedef struct packed {
      logic wr;
      logic [8:0] addr;
      logic [15:0] data;
   } reg_wr_t;
   // bootstrap init phase per high side, as seen by the bank
   typedef enum logic [1:0] {
      BOOT_DONE = 2'b00,
      BOOT_LOW = 2'b01,
      BOOT_HIGH = 2'b10
   } boot_phase_t;
   // which of 12 outputs (hs1..5, ls1..7) a core may drive
   typedef logic [11:0] out_mask_t;
endpackage

// *** verilog/masked_field_reg.sv ***
// one 16-bit register whose bits update under a per-bit write mask
`timescale 1ns/10ps
`default_nettype none
module masked_field_reg (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // write side
   input wire logic [15:0] bitEn,
   input wire logic [15:0] wrData,
   // stored value
   output logic [15:0] value
);
   // per-bit merge keeps unwritten and reserved fields untouched
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         value <= 16'h0000;
      end else begin
         value <= (value & ~bitEn) | (wrData & bitEn);
      end
   end
endmodule
`default_nettype wire

// *** verilog/predriver_threshold_slew_bias_regs.sv ***
// threshold, slew-rate and bias register bank of the gate pre-driver
// Summary of operation
// - three-bit thresholds (ls6 one bit at the drivers), all reset to zero
// - host writes thresholds at their offsets
// - core threshold/slew writes need output access
// - source threshold read shows bootstrap overrides
// - bias read shows bootstrap-adjusted enables
// - one slew code per output, ls7 two
// - slew codes: high side, then low side
// - bias enable per output, none for ls7
// - hs2 and hs4 add strong pull-up
// - core bias writes need output access
// - unauthorised core fields ignored, others update
// - init forces source threshold 0.5V then 1.0V
`timescale 1ns/10ps
`default_nettype none
`include "predriver_params.svh"
module predriver_threshold_slew_bias_regs (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // host register port
   input wire predriver_pkg::reg_wr_t hostReq,
   input wire logic hostRd,
   output logic [15:0] hostRdData,
   // microcore write ports, one per core
   input wire predriver_pkg::reg_wr_t [3:0] coreReq,
   // output_access_rights per core: bit0..4 hs1..5, bit5..11 ls1..7
   input wire predriver_pkg::out_mask_t [3:0] outputAccessRights,
   // bootstrap init state from the sequencer
   input wire predriver_pkg::boot_phase_t [4:0] bootPhase,
   // effective settings to the analog drivers
   output logic [15:0] hsDrainThr,
   output logic [15:0] hsSourceThr,
   output logic [15:0] lsDrainThr,
   output logic [15:0] hsEdgeSpeed,
   output logic [15:0] lsEdgeSpeed,
   output logic [15:0] biasEnables
);
   import predriver_pkg::*;

   // every port is on clk; host and core requests come from logic
   // on the same clock, so no synchroniser stands in front of them
   // number of mapped registers; unmapped addresses read zero
   localparam int NREG = 7;
   // register index order used by the bit-enable array
   logic [8:0] regAddr [NREG];
   logic [15:0] regMask [NREG];
   logic [15:0] bitEn [NREG];
   logic [15:0] wrData [NREG];
   logic [15:0] stored [NREG];
   // field owner map: output index per bit, 4'hf for reserved
   logic [3:0] owner [NREG][16];
   logic anyInit; // any high side still initialising
   logic [15:0] effSource; // source thresholds after overrides
   logic [15:0] effBias; // bias after overrides

   assign regAddr[0] = `ADDR_HS_DRAIN;
   assign regAddr[1] = `ADDR_HS_SOURCE;
   assign regAddr[2] = `ADDR_LS_DRAIN_LO;
   assign regAddr[3] = `ADDR_LS_DRAIN_HI;
   assign regAddr[4] = `ADDR_HS_SPEED;
   assign regAddr[5] = `ADDR_LS_SPEED;
   assign regAddr[6] = `ADDR_BIAS;
   assign regMask[0] = `MASK_THR5;
   assign regMask[1] = `MASK_THR5;
   assign regMask[2] = `MASK_THR5;
   assign regMask[3] = `MASK_THR1; // ls6 threshold alone in upper reg
   assign regMask[4] = `MASK_HS_SPEED;
   assign regMask[5] = `MASK_LS_SPEED;
   assign regMask[6] = `MASK_BIAS;

   // owner of each bit: which output the field belongs to
   // a constant map, kept as logic so the layout reads in one place
   always_comb begin
      for (int r = 0; r < NREG; r++) begin
         for (int b = 0; b < 16; b++) begin
            owner[r][b] = 4'hf;
         end
      end
      for (int b = 0; b < 15; b++) begin
         owner[0][b] = 4'(b / 3); // hs drain, hs1..5
         owner[1][b] = 4'(b / 3); // hs source
         owner[2][b] = 4'(5 + b / 3); // ls1..5 drain
      end
      for (int b = 0; b < 3; b++) begin
         owner[3][b] = 4'ha; // ls6
      end
      for (int b = 0; b < 10; b++) begin
         owner[4][b] = 4'(b / 2); // hs slew codes
      end
      for (int b = 0; b < 12; b++) begin
         owner[5][b] = 4'(5 + b / 2); // ls1..6 slew codes
      end
      for (int b = 12; b < 16; b++) begin
         owner[5][b] = 4'hb; // ls7 rising and falling codes
      end
      for (int b = 0; b < 5; b++) begin
         owner[6][b] = 4'(b); // hs pull-ups
      end
      for (int b = 5; b < 11; b++) begin
         owner[6][b] = 4'(b); // ls1..6 pull-downs
      end
      owner[6][`BIAS_HS2_STRONG] = 4'h1;
      owner[6][`BIAS_HS4_STRONG] = 4'h3;
   end

   // write arbitration: host first, then cores in index order;
   // a later writer wins a bit both touch in one cycle
   always_comb begin
      for (int r = 0; r < NREG; r++) begin
         bitEn[r] = 16'h0000;
         wrData[r] = 16'h0000;
         if (hostReq.wr && hostReq.addr == regAddr[r]) begin
            bitEn[r] = regMask[r];
            wrData[r] = hostReq.data;
         end
         for (int c = 0; c < `NUM_CORES; c++) begin
            if (coreReq[c].wr && coreReq[c].addr == regAddr[r]) begin
               for (int b = 0; b < 16; b++) begin
                  // only fields of granted outputs change
                  if (regMask[r][b] && owner[r][b] != 4'hf &&
                      outputAccessRights[c][owner[r][b]]) begin
                     bitEn[r][b] = 1'b1;
                     wrData[r][b] = coreReq[c].data[b];
                  end
               end
            end
         end
      end
   end

   // storage, one masked register per address
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : gReg
         masked_field_reg uReg (
            .clk(clk),
            .nrst(nrst),
            .bitEn(bitEn[g]),
            .wrData(wrData[g]),
            .value(stored[g])
         );
      end
   endgenerate

   // bootstrap overrides of source thresholds and bias
   always_comb begin
      anyInit = 1'b0;
      effSource = stored[1];
      effBias = stored[6];
      // each high side overrides only its own fields; the rest pass
      for (int h = 0; h < 5; h++) begin
         case (bootPhase[h])
            BOOT_LOW: begin
               effSource[h*3 +: 3] = `HS_SRC_HALF_VOLT;
               effBias[`BIAS_HS_PU_LSB + h] = 1'b0;
               anyInit = 1'b1;
            end
            BOOT_HIGH: begin
               effSource[h*3 +: 3] = `HS_SRC_ONE_VOLT;
               effBias[`BIAS_HS_PU_LSB + h] = 1'b0;
               anyInit = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // hs strong pull-ups follow their standard pull-up gating
      if (bootPhase[1] != BOOT_DONE) begin
         effBias[`BIAS_HS2_STRONG] = 1'b0;
      end
      if (bootPhase[3] != BOOT_DONE) begin
         effBias[`BIAS_HS4_STRONG] = 1'b0;
      end
      // all low-side pull-downs on while any high side initialises
      if (anyInit) begin
         effBias[`BIAS_LS_PD_LSB +: 6] = 6'h3f;
      end
   end

   // registering costs one cycle of latency but keeps the analog side
   // free of glitches from the override and arbitration logic
   // effective settings registered toward the drivers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hsDrainThr <= `RST_REG;
         hsSourceThr <= `RST_REG;
         lsDrainThr <= `RST_REG;
         hsEdgeSpeed <= `RST_REG;
         lsEdgeSpeed <= `RST_REG;
         biasEnables <= `RST_REG;
      end else begin
         hsDrainThr <= stored[0];
         hsSourceThr <= effSource;
         lsDrainThr <= {stored[3][0], stored[2][14:0]};
         hsEdgeSpeed <= stored[4];
         lsEdgeSpeed <= stored[5];
         biasEnables <= effBias;
      end
   end

   // a read in the same cycle as a write returns the old value, since
   // the stored word only changes at this very edge
   // host read data, registered one cycle after the read strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hostRdData <= 16'h0000;
      end else if (hostRd) begin
         case (hostReq.addr)
            `ADDR_HS_DRAIN: hostRdData <= stored[0];
            `ADDR_HS_SOURCE: hostRdData <= effSource;
            `ADDR_LS_DRAIN_LO: hostRdData <= stored[2];
            `ADDR_LS_DRAIN_HI: hostRdData <= stored[3];
            `ADDR_HS_SPEED: hostRdData <= stored[4];
            `ADDR_LS_SPEED: hostRdData <= stored[5];
            `ADDR_BIAS: hostRdData <= effBias;
            default: hostRdData <= 16'h0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** dv/predriver_regs_assertions.sv ***
// port checker for the threshold, slew and bias bank
`timescale 1ns/10ps
`default_nettype none
module predriver_regs_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // requests and boot state
   input wire predriver_pkg::reg_wr_t hostReq,
   input wire predriver_pkg::reg_wr_t [3:0] coreReq,
   input wire predriver_pkg::boot_phase_t [4:0] bootPhase,
   // driver settings
   input wire logic [15:0] hsDrainThr,
   input wire logic [15:0] hsSourceThr,
   input wire logic [15:0] hsEdgeSpeed,
   input wire logic [15:0] biasEnables
);
   import predriver_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // a core write in the same cycle would override the host
   logic hostOnly;
   assign hostOnly = hostReq.wr && hostReq.addr == 9'h18a &&
      !(coreReq[0].wr || coreReq[1].wr || coreReq[2].wr || coreReq[3].wr);
   property p_rst; $rose(nrst) |-> hsDrainThr == 0 && hsSourceThr == 0; endproperty
   a_rst: assert property (p_rst) else $error("not zero after reset");
   property p_hwr; hostOnly |-> ##2 hsDrainThr == ($past(hostReq.data, 2) & 16'h7fff); endproperty
   a_hwr: assert property (p_hwr) else $error("host write lost");
   property p_rsv; !hsDrainThr[15] && !hsSourceThr[15]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_spd; hsEdgeSpeed[15:10] == 6'h00; endproperty
   a_spd: assert property (p_spd) else $error("hs slew spare bits set");
   property p_bia; biasEnables[15:13] == 3'h0; endproperty
   a_bia: assert property (p_bia) else $error("bias spare bits set");
   property p_lo; (bootPhase[0] == BOOT_LOW)[*3] |-> hsSourceThr[2:0] == 3'h1; endproperty
   a_lo: assert property (p_lo) else $error("low init code missing");
   property p_hi; (bootPhase[0] == BOOT_HIGH)[*3] |-> hsSourceThr[2:0] == 3'h2; endproperty
   a_hi: assert property (p_hi) else $error("high init code missing");
   property p_ls; (bootPhase != 10'h000)[*3] |-> biasEnables[10:5] == 6'h3f; endproperty
   a_ls: assert property (p_ls) else $error("pull-downs not forced");
   property p_hs2; (bootPhase[1] != BOOT_DONE)[*3] |-> !biasEnables[1] && !biasEnables[11];
   endproperty
   a_hs2: assert property (p_hs2) else $error("hs2 pull-ups not masked");
endmodule
bind predriver_threshold_slew_bias_regs predriver_regs_assertions u_chk (.clk, .nrst,
   .hostReq, .coreReq, .bootPhase, .hsDrainThr, .hsSourceThr, .hsEdgeSpeed, .biasEnables);
`default_nettype wire

// *** dv/core_model.sv ***
// microcore model issuing single register writes
`timescale 1ns/10ps
`default_nettype none
module core_model (
   // clock
   input wire logic clk,
   // command from the bench
   input wire logic go,
   input wire logic [8:0] addr,
   input wire logic [15:0] data,
   // request to the bank
   output var predriver_pkg::reg_wr_t req
);
   // idle cycles carry garbage so a stale address is never trusted
   always_ff @(posedge clk) begin
      req <= go ? {1'b1, addr, data} : {1'b0, ~addr, ~data};
   end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the threshold, slew and bias bank
`timescale 1ns/10ps
`default_nettype none
module tb;
   import predriver_pkg::*;
   logic clk = 0, nrst = 0, hostRd = 0, go = 0, go1 = 0;
   reg_wr_t hostReq = '0, cmd = '0, cmd1 = '0;
   wire reg_wr_t [3:0] coreReq;
   out_mask_t [3:0] rights = '0;
   boot_phase_t [4:0] boot = {5{BOOT_DONE}};
   logic [15:0] rdData, hsD, hsS, lsD, hsE, lsE, bias;
   int n_fail = 0, samples_checked = 0;
   logic [8:0] adr[7] = '{9'h18a, 9'h18b, 9'h18c, 9'h18d, 9'h18e, 9'h18f, 9'h1a4};
   logic [15:0] msk[7] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h0007, 16'h03ff, 16'hffff, 16'h1fff};
   always #2 clk = ~clk;
   assign coreReq[3:2] = '0;
   core_model u_core (.clk, .go, .addr(cmd.addr), .data(cmd.data), .req(coreReq[0]));
   core_model u_core1 (.clk, .go(go1), .addr(cmd1.addr), .data(cmd1.data), .req(coreReq[1]));
   predriver_threshold_slew_bias_regs dut (.clk, .nrst, .hostReq, .hostRd, .hostRdData(rdData),
      .coreReq, .outputAccessRights(rights), .bootPhase(boot), .hsDrainThr(hsD),
      .hsSourceThr(hsS), .lsDrainThr(lsD), .hsEdgeSpeed(hsE), .lsEdgeSpeed(lsE),
      .biasEnables(bias));
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [8:0] a, logic [15:0] d);
      hostReq = {1'b1, a, d};
      @(posedge clk) #1 hostReq.wr = 0;
      // an idle edge keeps back-to-back write strobes apart
      @(posedge clk) #1;
   endtask
   // read data holds until the next read, so one spare edge is safe
   task automatic rd(logic [8:0] a, logic [15:0] exp);
      hostReq.addr = a;
      hostRd = 1;
      @(posedge clk) #1 hostRd = 0;
      @(posedge clk) #1 chk(rdData, exp);
   endtask
   task automatic cw(logic c, logic [8:0] a, logic [15:0] d);
      if (c) begin
         cmd1 = {1'b1, a, d};
         go1 = 1;
      end else begin
         cmd = {1'b1, a, d};
         go = 1;
      end
      @(posedge clk) #1 go = 0;
      go1 = 0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      foreach (adr[i]) rd(adr[i], 16'h0000);
      wr(9'h190, 16'hffff);
      rd(9'h190, 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_host;
      foreach (adr[i]) begin
         wr(adr[i], 16'hffff);
         rd(adr[i], msk[i]);
      end
      chk(hsD, 16'h7fff);
      chk(hsS, 16'h7fff);
      chk(lsD, 16'hffff);
      chk(hsE, 16'h03ff);
      chk(lsE, 16'hffff);
      chk(bias, 16'h1fff);
      foreach (adr[i]) wr(adr[i], 16'h0000);
      rd(9'h18f, 16'h0000);
      $display("host test done");
   endtask
   task automatic t_core;
      rights[0] = 12'h001;
      cw(1'b0, 9'h18e, 16'hffff);
      rd(9'h18e, 16'h0003);
      rights[0] = 12'h800;
      cw(1'b0, 9'h18f, 16'hffff);
      rd(9'h18f, 16'hf000);
      rights[0] = 12'h020;
      wr(9'h1a4, 16'h1fff);
      cw(1'b0, 9'h1a4, 16'h0000);
      rd(9'h1a4, 16'h1fdf);
      rights[0] = 12'h000;
      rights[1] = 12'h010;
      cw(1'b1, 9'h18a, 16'hffff);
      rd(9'h18a, 16'h7000);
      cw(1'b0, 9'h18a, 16'h0000);
      rd(9'h18a, 16'h7000);
      $display("core test done");
   endtask
   task automatic t_boot;
      wr(9'h18b, 16'h7fff);
      wr(9'h1a4, 16'h181f);
      boot[0] = BOOT_LOW;
      boot[1] = BOOT_LOW;
      repeat (3) @(posedge clk);
      #1;
      rd(9'h18b, 16'h7fc9);
      rd(9'h1a4, 16'h17fc);
      chk(hsS, 16'h7fc9);
      chk(bias, 16'h17fc);
      boot[0] = BOOT_HIGH;
      repeat (3) @(posedge clk);
      #1;
      rd(9'h18b, 16'h7fca);
      boot = {5{BOOT_DONE}};
      repeat (3) @(posedge clk);
      #1;
      rd(9'h18b, 16'h7fff);
      rd(9'h1a4, 16'h181f);
      $display("boot test done");
   endtask
   task automatic summarize;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 nrst = 1;
      @(posedge clk) #1;
      t_reset;
      t_host;
      t_core;
      t_boot;
      summarize;
   end
   initial begin
      #20000;
      n_fail++;
      summarize;
   end
endmodule
`default_nettype wire
